// ===== cfi_core.sv
`timescale 1ns/1ps

// Behaviour
// - Opcode field bits of each fetched instruction load the operation register and decode.
// - Decoded class drives all element controls at class-specific states.
// - Fetch phase copies program counter to address register of memory, then increments.
// - Jump loads program counter from effective address, then next fetch addresses it.
// - Fetch phase captures right half-word into address register for memory addressing.
// - Extra high address bit is captured with the address for the large bank.
// - One program counter, one address register, four index registers.
// - Index registers load up to two to seventeen less one; contents add to address.
// - Repeating indexed instruction decrements its index register every repetition.
// - Right accumulator may serve as a fifth index source.
// - Two identical arithmetic halves work on left and right half-words together.
// - Operands are handled alike whether they hold instructions or data.
// - Operand moves from memory buffer to A register before arithmetic.
// - Per-bit adders form sum and carry from accumulator and A bits.
// - Accumulators hold sum, difference, product high part, remainder; they shift.
// - B registers extend accumulators for multiply, divide and shift; no adder.
// - Operate instruction issues an unconditional command pulse to a unit.
// - Sense instruction branches on a synchronised unit status bit.
// - Selection checks an IO transfer is requested and starts the IO element.
// - IO element counts words, steps memory address, names unit, buffers words.
// - Core memory accesses are spaced at least one six microsecond cycle apart.
// - Memory address comes from program counter, effective address or IO address.
module cfi_core (
  input  wire logic              i_mclk,
  input  wire logic              i_rst_n,
  output cfi_pkg::cfi_mem_t      o_mem,
  input  wire logic              i_mem_rvalid,
  input  wire logic [31:0]       i_mem_rdata,
  input  wire logic [7:0]        i_unit_status,
  output cfi_pkg::cfi_opr_t      o_operate,
  output cfi_pkg::cfi_io_t       o_io,
  input  wire logic              i_io_valid,
  input  wire logic [31:0]       i_io_word,
  input  wire logic              i_io_take,
  output logic                   o_program_fetch_phase,
  output logic                   o_halted
);

  typedef struct packed {
    cfi_pkg::cfi_state_t st;
    logic [16:0]         pc;
    logic [16:0]         ar;
    logic [11:0]         opreg;
    logic [3:0][16:0]    xr;
    logic [1:0][15:0]    acc;
    logic [1:0][15:0]    a;
    logic [1:0][15:0]    b;
    logic [3:0]          step;
    logic [9:0]          gap;
    logic [31:0]         iobuf;
    logic [16:0]         ioaddr;
    logic [15:0]         iocnt;
    logic [3:0]          iounit;
    logic                iodir;
    logic [2:0][7:0]     sy;
    logic [7:0]          stat;
    cfi_pkg::cfi_mem_t   mem;
    cfi_pkg::cfi_opr_t   opr;
    logic                ftch;
    logic                halted;
  } cfi_regs_t;

  cfi_regs_t s;
  cfi_regs_t next_s;

  function automatic logic [4:0] op_class(input logic [11:0] op);
    return op[cfi_pkg::CLS_LSB +: 5];
  endfunction

  function automatic logic [2:0] op_idx(input logic [11:0] op);
    return op[cfi_pkg::IDX_LSB +: 3];
  endfunction

  // Ripple adder, sum and carry per bit
  function automatic logic [16:0] add16(input logic [15:0] x,
                                        input logic [15:0] y,
                                        input logic        cin);
    logic        c;
    logic [15:0] sm;
    c  = cin;
    sm = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      sm[i] = x[i] ^ y[i] ^ c;
      c     = (x[i] & y[i]) | (c & (x[i] ^ y[i]));
    end
    return {c, sm};
  endfunction

  logic [16:0] ea;
  logic [16:0] sum;
  logic [16:0] rem;
  logic [2:0]  isel;
  logic        rpt_ok;

  // Effective address; the stored instruction is never rewritten
  always_comb begin
    isel = op_idx(s.opreg);
    case (isel)
      3'h1, 3'h2, 3'h3, 3'h4: ea = 17'(s.ar + s.xr[isel - 3'h1]);
      cfi_pkg::IDX_RACC:      ea = 17'(s.ar + {1'b0, s.acc[1]});
      default:                ea = s.ar;
    endcase
    rpt_ok = s.opreg[cfi_pkg::RPT_BIT] && isel >= 3'h1 && isel <= 3'h4;
  end

  always_comb begin
    next_s         = s;
    sum            = 17'h00000;
    rem            = 17'h00000;
    next_s.mem.req = 1'b0;
    next_s.mem.we  = 1'b0;
    next_s.opr.valid = 1'b0;
    next_s.ftch    = 1'b0;
    if (s.gap != 10'h000) begin
      next_s.gap = s.gap - 10'h001;
    end
    next_s.sy[0] = i_unit_status;
    next_s.sy[1] = s.sy[0];
    next_s.sy[2] = s.sy[1];
    if (s.sy[1] == s.sy[2]) begin
      next_s.stat = s.sy[2];
    end
    case (s.st)
      cfi_pkg::ST_FETCH: begin
        if (s.gap == 10'h000) begin
          next_s.mem.req  = 1'b1;
          next_s.mem.addr = s.pc;
          next_s.pc       = 17'(s.pc + 17'h00001);
          next_s.gap      = cfi_pkg::GAP_LOAD;
          next_s.ftch     = 1'b1;
          next_s.st       = cfi_pkg::ST_FWAIT;
        end
      end
      cfi_pkg::ST_FWAIT: begin
        if (i_mem_rvalid) begin
          next_s.opreg = i_mem_rdata[cfi_pkg::OPC_LSB +: 12];
          next_s.ar    = {i_mem_rdata[cfi_pkg::LS_BIT], i_mem_rdata[15:0]};
          next_s.st    = cfi_pkg::ST_DECODE;
        end
      end
      cfi_pkg::ST_DECODE: begin
        next_s.st = cfi_pkg::ST_FETCH;
        case (op_class(s.opreg))
          cfi_pkg::CL_HALT: begin
            next_s.halted = 1'b1;
            next_s.st     = cfi_pkg::ST_HALT;
          end
          cfi_pkg::CL_JUMP: begin
            next_s.pc = ea;
          end
          cfi_pkg::CL_BRNEG: begin
            if (s.acc[0][15]) begin
              next_s.pc = ea;
            end
          end
          cfi_pkg::CL_LDIDX: begin
            if (isel >= 3'h1 && isel <= 3'h4) begin
              next_s.xr[isel - 3'h1] = s.ar;
            end
          end
          cfi_pkg::CL_SHIFT, cfi_pkg::CL_ROUND: begin
            next_s.st = cfi_pkg::ST_EXEC;
          end
          cfi_pkg::CL_OPER: begin
            next_s.opr.valid = 1'b1;
            next_s.opr.code  = s.ar[7:0];
          end
          cfi_pkg::CL_SENSE: begin
            if (s.stat[s.opreg[2:0]]) begin
              next_s.pc = ea;
            end
          end
          cfi_pkg::CL_IORD, cfi_pkg::CL_IOWR: begin
            if (s.acc[1] != 16'h0000) begin
              next_s.iocnt  = s.acc[1];
              next_s.ioaddr = ea;
              next_s.iounit = s.opreg[3:0];
              next_s.iodir  = op_class(s.opreg) == cfi_pkg::CL_IOWR;
              next_s.st     = next_s.iodir ? cfi_pkg::ST_IOMEM : cfi_pkg::ST_IOUNIT;
            end
          end
          cfi_pkg::CL_CLRADD, cfi_pkg::CL_ADD, cfi_pkg::CL_SUB,
          cfi_pkg::CL_STORE, cfi_pkg::CL_MUL, cfi_pkg::CL_DIV: begin
            next_s.st = cfi_pkg::ST_OPREQ;
          end
          default: begin
            next_s.st = cfi_pkg::ST_FETCH;
          end
        endcase
      end
      cfi_pkg::ST_OPREQ: begin
        if (s.gap == 10'h000) begin
          next_s.mem.req  = 1'b1;
          next_s.mem.addr = ea;
          next_s.gap      = cfi_pkg::GAP_LOAD;
          if (op_class(s.opreg) == cfi_pkg::CL_STORE) begin
            next_s.mem.we    = 1'b1;
            next_s.mem.wdata = {s.acc[0], s.acc[1]};
            next_s.st        = cfi_pkg::ST_NEXT;
          end else begin
            next_s.st = cfi_pkg::ST_OPWAIT;
          end
        end
      end
      cfi_pkg::ST_OPWAIT: begin
        if (i_mem_rvalid) begin
          next_s.a[0] = i_mem_rdata[31:16];
          next_s.a[1] = i_mem_rdata[15:0];
          next_s.st   = cfi_pkg::ST_EXEC;
        end
      end
      cfi_pkg::ST_EXEC: begin
        next_s.st   = cfi_pkg::ST_NEXT;
        next_s.step = 4'h0;
        for (int h = 0; h < 2; h++) begin
          case (op_class(s.opreg))
            cfi_pkg::CL_CLRADD: begin
              sum           = add16(16'h0000, s.a[h], 1'b0);
              next_s.acc[h] = sum[15:0];
              next_s.a[h]   = 16'h0000;
            end
            cfi_pkg::CL_ADD: begin
              sum           = add16(s.acc[h], s.a[h], 1'b0);
              next_s.acc[h] = sum[15:0];
              next_s.a[h]   = 16'h0000;
            end
            cfi_pkg::CL_SUB: begin
              sum           = add16(s.acc[h], ~s.a[h], 1'b1);
              next_s.acc[h] = sum[15:0];
              next_s.a[h]   = 16'h0000;
            end
            cfi_pkg::CL_MUL: begin
              next_s.b[h]   = s.acc[h];
              next_s.acc[h] = 16'h0000;
              next_s.st     = cfi_pkg::ST_MDS;
            end
            cfi_pkg::CL_DIV: begin
              next_s.st = cfi_pkg::ST_MDS;
            end
            cfi_pkg::CL_SHIFT: begin
              {next_s.acc[h], next_s.b[h]} =
                {s.acc[h], s.b[h]} >> ({1'b0, s.opreg[2:0]} + 4'h1);
            end
            cfi_pkg::CL_ROUND: begin
              sum           = add16(s.acc[h], 16'h0000, s.b[h][15]);
              next_s.acc[h] = sum[15:0];
              next_s.b[h]   = 16'h0000;
            end
            default: begin
              next_s.st = cfi_pkg::ST_NEXT;
            end
          endcase
        end
      end
      cfi_pkg::ST_MDS: begin
        next_s.step = s.step + 4'h1;
        for (int h = 0; h < 2; h++) begin
          if (op_class(s.opreg) == cfi_pkg::CL_MUL) begin
            sum           = s.b[h][0] ? add16(s.acc[h], s.a[h], 1'b0) : {1'b0, s.acc[h]};
            next_s.acc[h] = sum[16:1];
            next_s.b[h]   = {sum[0], s.b[h][15:1]};
          end else begin
            rem = {s.acc[h], s.b[h][15]};
            if (rem >= {1'b0, s.a[h]}) begin
              next_s.acc[h] = 16'(rem - {1'b0, s.a[h]});
              next_s.b[h]   = {s.b[h][14:0], 1'b1};
            end else begin
              next_s.acc[h] = rem[15:0];
              next_s.b[h]   = {s.b[h][14:0], 1'b0};
            end
          end
        end
        if (s.step == cfi_pkg::MUL_STEPS) begin
          next_s.st = cfi_pkg::ST_NEXT;
        end
      end
      cfi_pkg::ST_NEXT: begin
        next_s.st = cfi_pkg::ST_FETCH;
        if (rpt_ok && s.xr[isel - 3'h1] != 17'h00000) begin
          next_s.xr[isel - 3'h1] = 17'(s.xr[isel - 3'h1] - 17'h00001);
          next_s.st              = cfi_pkg::ST_OPREQ;
        end
      end
      cfi_pkg::ST_IOUNIT: begin
        if (!s.iodir && i_io_valid) begin
          next_s.iobuf = i_io_word;
          next_s.st    = cfi_pkg::ST_IOMEM;
        end else if (s.iodir && i_io_take) begin
          next_s.st = (s.iocnt == 16'h0000) ? cfi_pkg::ST_FETCH : cfi_pkg::ST_IOMEM;
        end
      end
      cfi_pkg::ST_IOMEM: begin
        if (s.gap == 10'h000) begin
          next_s.mem.req  = 1'b1;
          next_s.mem.addr = s.ioaddr;
          next_s.gap      = cfi_pkg::GAP_LOAD;
          if (s.iodir) begin
            next_s.st = cfi_pkg::ST_IOWAIT;
          end else begin
            next_s.mem.we    = 1'b1;
            next_s.mem.wdata = s.iobuf;
            next_s.ioaddr    = 17'(s.ioaddr + 17'h00001);
            next_s.iocnt     = s.iocnt - 16'h0001;
            next_s.st = (s.iocnt == 16'h0001) ? cfi_pkg::ST_FETCH : cfi_pkg::ST_IOUNIT;
          end
        end
      end
      cfi_pkg::ST_IOWAIT: begin
        if (i_mem_rvalid) begin
          next_s.iobuf  = i_mem_rdata;
          next_s.ioaddr = 17'(s.ioaddr + 17'h00001);
          next_s.iocnt  = s.iocnt - 16'h0001;
          next_s.st     = cfi_pkg::ST_IOUNIT;
        end
      end
      cfi_pkg::ST_HALT: begin
        next_s.halted = 1'b1;
      end
      default: begin
        next_s.st = cfi_pkg::ST_FETCH;
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      s    <= '0;
      s.pc <= cfi_pkg::PC_RESET;
    end else begin
      s <= next_s;
    end
  end

  // Unit-facing handshakes from state
  always_comb begin
    o_io.busy       = s.st == cfi_pkg::ST_IOUNIT || s.st == cfi_pkg::ST_IOMEM ||
                      s.st == cfi_pkg::ST_IOWAIT;
    o_io.unit       = s.iounit;
    o_io.to_unit    = s.iodir;
    o_io.ready      = s.st == cfi_pkg::ST_IOUNIT && !s.iodir;
    o_io.word_valid = s.st == cfi_pkg::ST_IOUNIT && s.iodir;
    o_io.word       = s.iobuf;
  end

  assign o_mem                 = s.mem;
  assign o_operate             = s.opr;
  assign o_program_fetch_phase = s.ftch;
  assign o_halted              = s.halted;

endmodule // cfi_core

// ===== cfi_core_properties.sv
`timescale 1ns/1ps
module cfi_core_properties (
  input  wire logic         i_mclk,
  input  wire logic         i_rst_n,
  input  cfi_pkg::cfi_mem_t o_mem,
  input  cfi_pkg::cfi_opr_t o_operate,
  input  cfi_pkg::cfi_io_t  o_io,
  input  wire logic         i_io_valid,
  input  wire logic         i_io_take,
  input  wire logic         o_program_fetch_phase,
  input  wire logic         o_halted
);
  localparam int GAP_MIN = 749;
  logic [9:0] gap;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  // Cycles since last request, saturating
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) gap <= 10'h3FF;
    else if (o_mem.req) gap <= 10'h000;
    else if (gap != 10'h3FF) gap <= gap + 10'h001;
  end
  sequence s_unit_word;
    o_io.ready && i_io_valid;
  endsequence
  sequence s_word_stored;
    ##1 !o_io.ready ##[0:760] (o_mem.req && o_mem.we);
  endsequence
  property p_gap; o_mem.req |-> gap >= GAP_MIN; endproperty
  property p_fetch; o_program_fetch_phase |-> o_mem.req && !o_mem.we; endproperty
  property p_we; o_mem.we |-> o_mem.req; endproperty
  property p_addr; !o_mem.req |-> $stable(o_mem.addr); endproperty
  property p_halt; o_halted |=> o_halted && !o_mem.req && !o_operate.valid; endproperty
  property p_opr; o_operate.valid |=> !o_operate.valid; endproperty
  property p_ready; o_io.ready |-> o_io.busy && !o_io.to_unit; endproperty
  property p_word;
    o_io.word_valid && !i_io_take |=> o_io.word_valid && $stable(o_io.word);
  endproperty
  property p_store; s_unit_word |-> s_word_stored; endproperty
  a_gap: assert property (p_gap) else $error("memory requests too close");
  a_fetch: assert property (p_fetch) else $error("fetch phase without read");
  a_we: assert property (p_we) else $error("write without request");
  a_addr: assert property (p_addr) else $error("address moved while idle");
  a_halt: assert property (p_halt) else $error("activity after halt");
  a_opr: assert property (p_opr) else $error("operate pulse too long");
  a_ready: assert property (p_ready) else $error("ready outside transfer");
  a_word: assert property (p_word) else $error("unit word not held");
  a_store: assert property (p_store) else $error("unit word not stored");
endmodule // cfi_core_properties

bind cfi_core cfi_core_properties u_props (
  .i_mclk(i_mclk), .i_rst_n(i_rst_n), .o_mem(o_mem), .o_operate(o_operate),
  .o_io(o_io), .i_io_valid(i_io_valid), .i_io_take(i_io_take),
  .o_program_fetch_phase(o_program_fetch_phase), .o_halted(o_halted)
);

// ===== cfi_core_tb_top.sv
`timescale 1ns/1ps
module cfi_core_tb_top;
  logic              i_mclk;
  logic              i_rst_n;
  cfi_pkg::cfi_mem_t o_mem;
  logic              i_mem_rvalid;
  logic [31:0]       i_mem_rdata;
  logic [7:0]        i_unit_status;
  cfi_pkg::cfi_opr_t o_operate;
  cfi_pkg::cfi_io_t  o_io;
  logic              i_io_valid = 1'b0;
  logic [31:0]       i_io_word;
  logic              i_io_take = 1'b0;
  logic              o_program_fetch_phase;
  logic              o_halted;
  int                fails;
  int                compares;
  int                opr_n = 0;
  logic [7:0]        opr_code;
  logic [31:0]       rx_word;
  logic [3:0]        rx_unit;
  int                fetch_n = 0;
  logic [16:0]       wr_addr;

  cfi_core DUT (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .o_mem(o_mem), .i_mem_rvalid(i_mem_rvalid),
    .i_mem_rdata(i_mem_rdata), .i_unit_status(i_unit_status), .o_operate(o_operate),
    .o_io(o_io), .i_io_valid(i_io_valid), .i_io_word(i_io_word), .i_io_take(i_io_take),
    .o_program_fetch_phase(o_program_fetch_phase), .o_halted(o_halted)
  );
  cfi_mem_model u_mem (
    .i_mclk(i_mclk), .i_mem(o_mem), .o_rvalid(i_mem_rvalid), .o_rdata(i_mem_rdata)
  );

  initial begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end

  // IO unit stand-in and operate monitor
  always @(posedge i_mclk) begin
    i_io_valid <= o_io.ready;
    i_io_take <= o_io.word_valid;
    if (o_operate.valid === 1'b1) begin
      opr_n <= opr_n + 1;
      opr_code <= o_operate.code;
    end
    if (o_io.word_valid === 1'b1 && i_io_take === 1'b1) begin
      rx_word <= o_io.word;
      rx_unit <= o_io.unit;
    end
    if (o_program_fetch_phase === 1'b1) begin
      fetch_n <= fetch_n + 1;
    end
    if (o_mem.req === 1'b1 && o_mem.we === 1'b1) begin
      wr_addr <= o_mem.addr;
    end
  end

  task automatic conclude();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] ins(input logic [4:0] c, input logic [2:0] s,
                                      input logic [2:0] v, input logic [15:0] a);
    return {c, s, 1'b0, v, 4'h0, a};
  endfunction

  task automatic clr();
    for (int i = 0; i < 256; i++) u_mem.m[i] = 32'h0;
  endtask

  task automatic run();
    int n;
    i_rst_n <= 1'b0;
    repeat (6) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    n = 0;
    @(negedge i_mclk);
    while (o_halted !== 1'b1 && n < 20000) begin
      @(negedge i_mclk);
      n++;
    end
    @(posedge i_mclk);
    if (n >= 20000) begin
      fails++;
      $display("ERROR %0t program did not halt", $time);
      conclude();
    end
  endtask

  task automatic t_add();
    logic [31:0] e;
    clr();
    e = ins(cfi_pkg::CL_STORE, 3'h0, 3'h0, 16'h0042);
    u_mem.m[0] = ins(cfi_pkg::CL_CLRADD, 3'h0, 3'h0, 16'h0040);
    u_mem.m[1] = ins(cfi_pkg::CL_ADD, 3'h0, 3'h0, 16'h0041);
    u_mem.m[2] = ins(cfi_pkg::CL_ADD, 3'h0, 3'h0, 16'h0003);
    u_mem.m[3] = e;
    u_mem.m[8'h40] = 32'hFFFF0001;
    u_mem.m[8'h41] = 32'h00010002;
    run();
    chk(u_mem.m[8'h42], {16'h0000 + e[31:16], 16'h0003 + e[15:0]});
  endtask

  task automatic t_index();
    clr();
    u_mem.m[0] = ins(cfi_pkg::CL_CLRADD, 3'h0, 3'h0, 16'h0040);
    u_mem.m[1] = ins(cfi_pkg::CL_ADD, cfi_pkg::IDX_RACC, 3'h0, 16'h0040);
    u_mem.m[2] = ins(cfi_pkg::CL_STORE, 3'h0, 3'h0, 16'h0043);
    u_mem.m[8'h40] = 32'h00000002;
    u_mem.m[8'h42] = 32'h00100010;
    run();
    chk(u_mem.m[8'h43], 32'h00100012);
    chk(u_mem.m[1], ins(cfi_pkg::CL_ADD, cfi_pkg::IDX_RACC, 3'h0, 16'h0040));
  endtask

  task automatic t_jump();
    clr();
    u_mem.m[0] = ins(cfi_pkg::CL_CLRADD, 3'h0, 3'h0, 16'h0040);
    u_mem.m[1] = ins(cfi_pkg::CL_SUB, 3'h0, 3'h0, 16'h0041);
    u_mem.m[2] = ins(cfi_pkg::CL_JUMP, 3'h0, 3'h0, 16'h0010);
    u_mem.m[8'h10] = ins(cfi_pkg::CL_STORE, 3'h0, 3'h0, 16'h0044);
    u_mem.m[8'h40] = 32'h00050003;
    u_mem.m[8'h41] = 32'h00020005;
    u_mem.m[8'h44] = 32'hFFFFFFFF;
    run();
    chk(u_mem.m[8'h44], 32'h0003FFFE);
  endtask

  task automatic t_sense();
    clr();
    i_unit_status <= 8'h08;
    u_mem.m[0] = ins(cfi_pkg::CL_OPER, 3'h0, 3'h0, 16'h005A);
    u_mem.m[1] = ins(cfi_pkg::CL_SENSE, 3'h0, 3'h2, 16'h0030);
    u_mem.m[2] = ins(cfi_pkg::CL_SENSE, 3'h0, 3'h3, 16'h0020);
    u_mem.m[8'h20] = ins(cfi_pkg::CL_STORE, 3'h0, 3'h0, 16'h0045);
    u_mem.m[8'h30] = ins(cfi_pkg::CL_STORE, 3'h0, 3'h0, 16'h0046);
    u_mem.m[8'h45] = 32'hFFFFFFFF;
    u_mem.m[8'h46] = 32'hFFFFFFFF;
    run();
    chk(u_mem.m[8'h45], 32'h00000000);
    chk(u_mem.m[8'h46], 32'hFFFFFFFF);
    chk({24'h0, opr_code}, 32'h0000005A);
    chk(32'(opr_n), 32'h00000001);
  endtask

  task automatic t_io();
    clr();
    u_mem.m[0] = ins(cfi_pkg::CL_CLRADD, 3'h0, 3'h0, 16'h0040);
    u_mem.m[1] = ins(cfi_pkg::CL_IORD, 3'h0, 3'h3, 16'h0048);
    u_mem.m[2] = ins(cfi_pkg::CL_IOWR, 3'h0, 3'h5, 16'h0040);
    u_mem.m[8'h40] = 32'h00000001;
    run();
    chk(u_mem.m[8'h48], i_io_word);
    chk(rx_word, 32'h00000001);
    chk({28'h0, rx_unit}, 32'h00000005);
  endtask

  task automatic t_muldiv();
    clr();
    u_mem.m[0] = ins(cfi_pkg::CL_CLRADD, 3'h0, 3'h0, 16'h0040);
    u_mem.m[1] = ins(cfi_pkg::CL_MUL, 3'h0, 3'h0, 16'h0041);
    u_mem.m[2] = ins(cfi_pkg::CL_STORE, 3'h0, 3'h0, 16'h0050);
    u_mem.m[3] = ins(cfi_pkg::CL_SHIFT, 3'h0, 3'h1, 16'h0000);
    u_mem.m[4] = ins(cfi_pkg::CL_ROUND, 3'h0, 3'h0, 16'h0000);
    u_mem.m[5] = ins(cfi_pkg::CL_STORE, 3'h0, 3'h0, 16'h0051);
    u_mem.m[6] = ins(cfi_pkg::CL_DIV, 3'h0, 3'h0, 16'h0042);
    u_mem.m[7] = ins(cfi_pkg::CL_ROUND, 3'h0, 3'h0, 16'h0000);
    u_mem.m[8] = ins(cfi_pkg::CL_STORE, 3'h0, 3'h0, 16'h0052);
    u_mem.m[8'h40] = 32'h8000FFFF;
    u_mem.m[8'h41] = 32'h0004FFFF;
    u_mem.m[8'h42] = 32'h00028001;
    run();
    chk(u_mem.m[8'h50], 32'h0002FFFE);
    chk(u_mem.m[8'h51], 32'h00014000);
    chk(u_mem.m[8'h52], 32'h00010001);
  endtask

  task automatic t_loop();
    int f0;
    clr();
    f0 = fetch_n;
    u_mem.m[0] = ins(cfi_pkg::CL_LDIDX, 3'h1, 3'h0, 16'h0002);
    u_mem.m[1] = ins(cfi_pkg::CL_CLRADD, 3'h0, 3'h0, 16'h0043);
    // Repeat bit set
    u_mem.m[2] = ins(cfi_pkg::CL_ADD, 3'h1, 3'h0, 16'h0040) | 32'h00800000;
    u_mem.m[3] = ins(cfi_pkg::CL_STORE, 3'h0, 3'h0, 16'h0044);
    u_mem.m[4] = ins(cfi_pkg::CL_BRNEG, 3'h0, 3'h0, 16'h0008);
    // Extra high address bit set
    u_mem.m[8] = ins(cfi_pkg::CL_STORE, 3'h1, 3'h0, 16'h0045) | 32'h00080000;
    u_mem.m[8'h40] = 32'h00010001;
    u_mem.m[8'h41] = 32'h00020002;
    u_mem.m[8'h42] = 32'h00040004;
    u_mem.m[8'h43] = 32'h80000001;
    run();
    chk(u_mem.m[8'h44], 32'h80070008);
    chk(u_mem.m[8'h45], 32'h80070008);
    chk({15'h0, wr_addr}, 32'h00010045);
    chk(32'(fetch_n - f0), 32'h00000007);
  endtask

  initial begin
    i_rst_n = 1'b0;
    i_unit_status = 8'h00;
    i_io_word = 32'h13579BDF;
    fails = 0;
    compares = 0;
    @(posedge i_mclk);
    t_add();
    t_index();
    t_jump();
    t_sense();
    t_io();
    t_muldiv();
    t_loop();
    conclude();
  end
endmodule // cfi_core_tb_top

// ===== cfi_mem_model.sv
`timescale 1ns/1ps
module cfi_mem_model (
  input  wire logic         i_mclk,
  input  cfi_pkg::cfi_mem_t i_mem,
  output logic              o_rvalid,
  output logic [31:0]       o_rdata
);
  logic [31:0] m [256];
  logic [7:0]  ra;
  logic [3:0]  wait_cnt;
  logic        pend;
  logic        slow;
  initial begin
    o_rvalid = 1'b0;
    o_rdata = 32'h0;
    pend = 1'b0;
    slow = 1'b0;
    wait_cnt = 4'h0;
  end
  // Alternates prompt and slow answers; data toggles when not valid
  always @(posedge i_mclk) begin
    o_rvalid <= 1'b0;
    o_rdata <= ~o_rdata;
    if (i_mem.req && i_mem.we) m[i_mem.addr[7:0]] <= i_mem.wdata;
    if (i_mem.req && !i_mem.we) begin
      pend <= 1'b1;
      ra <= i_mem.addr[7:0];
      wait_cnt <= slow ? 4'h9 : 4'h0;
      slow <= ~slow;
    end else if (pend && wait_cnt != 4'h0) begin
      wait_cnt <= wait_cnt - 4'h1;
    end else if (pend) begin
      pend <= 1'b0;
      o_rvalid <= 1'b1;
      o_rdata <= m[ra];
    end
  end
endmodule // cfi_mem_model

// ===== cfi_pkg.sv
package cfi_pkg;

  // Clock and core memory timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int MEM_CYCLE_NS  = 6000;
  localparam int MEM_GAP_CYC   = (MEM_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [9:0] GAP_LOAD = 10'(MEM_GAP_CYC - 1);

  // Instruction word layout (left half 31:16, right half 15:0)
  localparam int OPC_LSB = 20;
  localparam int LS_BIT  = 19;
  localparam int CLS_LSB = 7;
  localparam int IDX_LSB = 4;
  localparam int RPT_BIT = 3;

  localparam logic [16:0] PC_RESET  = 17'h00000;
  localparam logic [3:0]  MUL_STEPS = 4'hF;

  // Instruction classes
  localparam logic [4:0] CL_HALT   = 5'h00;
  localparam logic [4:0] CL_CLRADD = 5'h01;
  localparam logic [4:0] CL_ADD    = 5'h02;
  localparam logic [4:0] CL_SUB    = 5'h03;
  localparam logic [4:0] CL_STORE  = 5'h04;
  localparam logic [4:0] CL_JUMP   = 5'h05;
  localparam logic [4:0] CL_BRNEG  = 5'h06;
  localparam logic [4:0] CL_LDIDX  = 5'h07;
  localparam logic [4:0] CL_MUL    = 5'h08;
  localparam logic [4:0] CL_DIV    = 5'h09;
  localparam logic [4:0] CL_SHIFT  = 5'h0A;
  localparam logic [4:0] CL_ROUND  = 5'h0B;
  localparam logic [4:0] CL_OPER   = 5'h0C;
  localparam logic [4:0] CL_SENSE  = 5'h0D;
  localparam logic [4:0] CL_IORD   = 5'h0E;
  localparam logic [4:0] CL_IOWR   = 5'h0F;

  localparam logic [2:0] IDX_RACC = 3'h5;

  typedef enum logic [3:0] {
    ST_FETCH, ST_FWAIT, ST_DECODE, ST_OPREQ, ST_OPWAIT, ST_EXEC,
    ST_MDS, ST_NEXT, ST_IOUNIT, ST_IOMEM, ST_IOWAIT, ST_HALT
  } cfi_state_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [16:0] addr;
    logic [31:0] wdata;
  } cfi_mem_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] code;
  } cfi_opr_t;

  typedef struct packed {
    logic        busy;
    logic [3:0]  unit;
    logic        to_unit;
    logic        ready;
    logic        word_valid;
    logic [31:0] word;
  } cfi_io_t;

endpackage
